//--- verilog/port_pin_function_mux.sv
// Port and pin-function multiplexer for seven general ports, APB slave.
// Assumes pins arrive synchronous to pclk; pad wires are resolved outside.
`default_nettype none

module port_pin_function_mux (
  input  wire  logic                                pclk,            // System clock
  input  wire  logic                                presetn,         // Async reset, low
  input  wire  logic                                psel,            // APB select
  input  wire  logic                                penable,         // APB access phase
  input  wire  logic                                pwrite,          // APB write
  input  wire  logic [pinmux_pkg::ADDR_W-1:0]       paddr,           // APB byte address
  input  wire  logic [31:0]                         pwdata,          // APB write data
  output logic       [31:0]                         prdata,          // APB read data
  output logic                                      pready,          // APB ready
  output logic                                      pslverr,         // APB error
  input  wire  logic [3:0]                          pa_in,           // Port a pin levels
  output logic       [3:0]                          pa_out,          // Port a pin data
  output logic       [3:0]                          pa_oe,           // Port a drive enable
  output logic       [3:0]                          pa_pullup,       // Port a pull-up on
  input  wire  logic [4:0]                          pb_in,           // Port b pin levels
  output logic       [4:0]                          adc_in_sel,      // Port b analogue select
  output logic       [7:0]                          pc_out,          // Port c pin data
  output logic       [7:0]                          pc_oe,           // Port c drive enable
  input  wire  logic [3:0]                          pd_in,           // Port d pin levels
  output logic       [3:0]                          pd_out,          // Port d pin data
  output logic       [3:0]                          pd_oe,           // Port d drive enable
  input  wire  logic [7:0]                          pe_in,           // Port e pin levels
  output logic       [7:0]                          pe_out,          // Port e pin data
  output logic       [7:0]                          pe_oe,           // Port e drive enable
  output logic       [7:0]                          pf_out,          // Port f pin data
  output logic       [7:0]                          pf_oe,           // Port f drive enable
  input  wire  logic [5:0]                          pg_in,           // Port g pin levels
  output logic       [5:0]                          pg_out,          // Port g pin data
  output logic       [5:0]                          pg_oe,           // Port g drive enable
  input  wire  logic [7:0]                          meter12_pwm,     // Meter 1 (3:0), 2 (7:4)
  input  wire  logic [7:0]                          meter34_pwm,     // Meter 3 (3:0), 4 (7:4)
  input  wire  pinmux_pkg::alt_t                    pd_alt,          // Serial/timer/LCD drive
  input  wire  logic [7:0]                          lcd_segment_zero,// LCD segments 0 to 7
  input  wire  pinmux_pkg::alt_t                    pg_alt,          // Sound/clock/UART drive
  output logic       [2:0]                          ext_irq,         // Interrupt edge pulses
  output logic                                      can_ext_clock_in,// CAN clock from pin
  output logic                                      tmr8_a_count_in, // Timer count clock
  output logic                                      csi_a_clock_in,  // Serial clock in
  output logic                                      csi_a_data_in,   // Serial data in
  output logic                                      async_rx_in,     // UART receive data
  output logic                                      cap_trigger_a,   // Capture trigger a
  output logic                                      cap_trigger_b    // Capture trigger b
);

  logic [7:0]              cfg [pinmux_pkg::REG_N];
  logic [3:0]              pa_prev;
  logic [4:0]              idx;
  logic                    hit;
  logic                    setup_done;
  logic                    done;
  logic [31:0]             next_prdata;
  logic                    next_err;
  logic [4:0]              pb_digital;
  pinmux_pkg::alt_t        next_a;
  pinmux_pkg::alt_t        next_c;
  pinmux_pkg::alt_t        next_d;
  pinmux_pkg::alt_t        next_e;
  pinmux_pkg::alt_t        next_f;
  pinmux_pkg::alt_t        next_g;
  logic [2:0]              next_irq;
  logic [2:0]              rise_seen;
  logic [2:0]              fall_seen;

  // Per-pin selection shared by every port except b
  function automatic pinmux_pkg::alt_t pin_mux(input logic [7:0]        latch,
                                               input logic [7:0]        dir_in,
                                               input logic [7:0]        ctrl,
                                               input pinmux_pkg::alt_t  alt);
    pinmux_pkg::alt_t r;
    r.o  = (ctrl & alt.o) | (~ctrl & latch);
    r.oe = (ctrl & alt.oe) | (~ctrl & ~dir_in);
    return r;
  endfunction

  // Address decode; upper address bits must be zero
  assign idx        = paddr[6:2];
  assign hit        = (paddr[pinmux_pkg::ADDR_W-1:7] == '0) && (paddr[1:0] == 2'h0);
  assign setup_done = psel & penable & ~pready;
  assign done       = psel & penable & pready;

  // Analogue-selected bits read back as zero on the digital side
  assign pb_digital = pb_in & ~cfg[pinmux_pkg::PB_ANA][4:0];

  // Read data and error, captured one cycle into the access phase
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    if (!hit) begin
      next_err = 1'b1;
    end else if (idx < 5'(pinmux_pkg::REG_N)) begin
      next_prdata = {24'h00_0000, cfg[idx]};
    end else if (idx == pinmux_pkg::PIN_ABD) begin
      next_prdata = {19'h0_0000, pd_in, pb_digital, pa_in};
    end else if (idx == pinmux_pkg::PIN_EG) begin
      next_prdata = {18'h0_0000, pg_in, pe_in};
    end else begin
      next_err = 1'b1;
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_done;
    end
  end

  // Read data and error stand only while pready is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      if (setup_done) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_err;
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // Configuration store; writes land at the completing edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < pinmux_pkg::REG_N; i++) begin
        cfg[i] <= pinmux_pkg::REG_RST[i];
      end
    end else if (done && pwrite && hit && idx < 5'(pinmux_pkg::REG_N)) begin
      cfg[idx] <= pwdata[7:0] & pinmux_pkg::REG_MASK[idx];
    end
  end

  // Port a: per-bit direction, interrupt and CAN clock are inputs
  assign next_a = pin_mux({4'h0, cfg[pinmux_pkg::PA_LATCH][3:0]},
                          {4'hf, cfg[pinmux_pkg::PA_DIR][3:0]},
                          {4'h0, cfg[pinmux_pkg::PA_CTRL][3:0]},
                          '{o: 8'h00, oe: 8'h00});

  // Port c: output only, meter 1 and 2 in control mode
  assign next_c = pin_mux(cfg[pinmux_pkg::PC_LATCH], cfg[pinmux_pkg::PC_OFF],
                          cfg[pinmux_pkg::PC_CTRL],
                          '{o: meter12_pwm, oe: 8'hff});

  // Port d: serial, timer, LCD drive supplied per pin by peripherals
  assign next_d = pin_mux({4'h0, cfg[pinmux_pkg::PD_LATCH][3:0]},
                          {4'hf, cfg[pinmux_pkg::PD_DIR][3:0]},
                          {4'h0, cfg[pinmux_pkg::PD_CTRL][3:0]},
                          pd_alt);

  // Port e: LCD segments take the whole byte at once
  assign next_e = pin_mux(cfg[pinmux_pkg::PE_LATCH], cfg[pinmux_pkg::PE_DIR],
                          {8{cfg[pinmux_pkg::PE_CTRL][0]}},
                          '{o: lcd_segment_zero, oe: 8'hff});

  // Port f: output only, meter 3 and 4 in control mode
  assign next_f = pin_mux(cfg[pinmux_pkg::PF_LATCH], cfg[pinmux_pkg::PF_OFF],
                          cfg[pinmux_pkg::PF_CTRL],
                          '{o: meter34_pwm, oe: 8'hff});

  // Port g: sound, clock out, UART, capture pins
  assign next_g = pin_mux({2'h0, cfg[pinmux_pkg::PG_LATCH][5:0]},
                          {2'h3, cfg[pinmux_pkg::PG_DIR][5:0]},
                          {2'h0, cfg[pinmux_pkg::PG_CTRL][5:0]},
                          pg_alt);

  // Edge detector; pins only, port-mode bits never interrupt
  assign rise_seen = pa_in[2:0] & ~pa_prev[2:0];
  assign fall_seen = ~pa_in[2:0] & pa_prev[2:0];
  assign next_irq  = cfg[pinmux_pkg::PA_CTRL][2:0] &
                     ((cfg[pinmux_pkg::PA_EDGE][pinmux_pkg::EDGE_RISE_LSB +: 3] & rise_seen) |
                      (cfg[pinmux_pkg::PA_EDGE][pinmux_pkg::EDGE_FALL_LSB +: 3] & fall_seen));

  // Port a pads; reset leaves every pad undriven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_out    <= 4'h0;
      pa_oe     <= 4'h0;
      pa_pullup <= 4'h0;
    end else begin
      pa_out    <= next_a.o[3:0];
      pa_oe     <= next_a.oe[3:0];
      pa_pullup <= cfg[pinmux_pkg::PA_PULL][3:0] & ~next_a.oe[3:0];
    end
  end

  // Port c pads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_out <= 8'h00;
      pc_oe  <= 8'h00;
    end else begin
      pc_out <= next_c.o;
      pc_oe  <= next_c.oe;
    end
  end

  // Port d pads; serial direction comes from the peripheral
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_out <= 4'h0;
      pd_oe  <= 4'h0;
    end else begin
      pd_out <= next_d.o[3:0];
      pd_oe  <= next_d.oe[3:0];
    end
  end

  // Port e pads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe_out <= 8'h00;
      pe_oe  <= 8'h00;
    end else begin
      pe_out <= next_e.o;
      pe_oe  <= next_e.oe;
    end
  end

  // Port f pads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_out <= 8'h00;
      pf_oe  <= 8'h00;
    end else begin
      pf_out <= next_f.o;
      pf_oe  <= next_f.oe;
    end
  end

  // Port g pads; sound pins stay inputs until configured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_out <= 6'h00;
      pg_oe  <= 6'h00;
    end else begin
      pg_out <= next_g.o[5:0];
      pg_oe  <= next_g.oe[5:0];
    end
  end

  // Analogue select; port b has no drivers at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_in_sel <= 5'h00;
    end else begin
      adc_in_sel <= cfg[pinmux_pkg::PB_ANA][4:0];
    end
  end

  // Interrupt pulses; edges count only in control mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_prev <= 4'h0;
      ext_irq <= 3'h0;
    end else begin
      pa_prev <= pa_in;
      ext_irq <= next_irq;
    end
  end

  // CAN clock; gating keeps peripherals quiet in port mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can_ext_clock_in <= 1'b0;
    end else begin
      can_ext_clock_in <= pa_in[pinmux_pkg::PA_CAN_BIT] &
                          cfg[pinmux_pkg::PA_CTRL][pinmux_pkg::PA_CAN_BIT];
    end
  end

  // Timer count clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr8_a_count_in <= 1'b0;
    end else begin
      tmr8_a_count_in <= pd_in[pinmux_pkg::PD_TMR_BIT] &
                         cfg[pinmux_pkg::PD_CTRL][pinmux_pkg::PD_TMR_BIT];
    end
  end

  // Serial clock input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csi_a_clock_in <= 1'b0;
    end else begin
      csi_a_clock_in <= pd_in[pinmux_pkg::PD_SCK_BIT] &
                        cfg[pinmux_pkg::PD_CTRL][pinmux_pkg::PD_SCK_BIT];
    end
  end

  // Serial data input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csi_a_data_in <= 1'b0;
    end else begin
      csi_a_data_in <= pd_in[pinmux_pkg::PD_SI_BIT] &
                       cfg[pinmux_pkg::PD_CTRL][pinmux_pkg::PD_SI_BIT];
    end
  end

  // UART receive data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_rx_in <= 1'b0;
    end else begin
      async_rx_in <= pg_in[pinmux_pkg::PG_RX_BIT] &
                     cfg[pinmux_pkg::PG_CTRL][pinmux_pkg::PG_RX_BIT];
    end
  end

  // Capture trigger a
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_trigger_a <= 1'b0;
    end else begin
      cap_trigger_a <= pg_in[pinmux_pkg::PG_CAPA_BIT] &
                       cfg[pinmux_pkg::PG_CTRL][pinmux_pkg::PG_CAPA_BIT];
    end
  end

  // Capture trigger b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_trigger_b <= 1'b0;
    end else begin
      cap_trigger_b <= pg_in[pinmux_pkg::PG_CAPB_BIT] &
                       cfg[pinmux_pkg::PG_CTRL][pinmux_pkg::PG_CAPB_BIT];
    end
  end

endmodule

`default_nettype wire

//--- verilog/pinmux_pkg.sv
// Constants, register map and carrier types for the port pin multiplexer.
// Assumes a single 20 MHz APB clock domain and synchronous pin inputs.
// Function
// - First port: four pins, input or output
// - First port direction set bit by bit
// - Pull-up only on input pins when enabled
// - Control mode: edge-selectable external interrupt inputs
// - One first-port pin feeds CAN clock
// - Second port: five pins, input only
// - Second port bits switch digital or analogue
// - Third port: eight pins, output only
// - Third port carries meter one/two PWM
// - Fourth port: per-bit direction and function
// - Fourth port carries serial, timer, LCD signals
// - Fifth port: eight pins, per-bit direction
// - Fifth port LCD segments selected byte-wise
// - Sixth port: output only, meter three/four PWM
// - Seventh port: six pins, capture, clock, UART, sound
// - Two seventh-port pins trigger timer capture
// - Sound generator pins come up as inputs
// - Interrupt pins are inputs after reset
`default_nettype none

package pinmux_pkg;

  // Drive bundle for one port: data and output enable per pin
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } alt_t;

  localparam int         ADDR_W = 12;
  localparam int         REG_N  = 21;
  // Word indexes; byte address is four times the index
  localparam logic [4:0] PA_LATCH = 5'h00;
  localparam logic [4:0] PA_DIR   = 5'h01;
  localparam logic [4:0] PA_CTRL  = 5'h02;
  localparam logic [4:0] PA_PULL  = 5'h03;
  localparam logic [4:0] PA_EDGE  = 5'h04;
  localparam logic [4:0] PB_ANA   = 5'h05;
  localparam logic [4:0] PC_LATCH = 5'h06;
  localparam logic [4:0] PC_OFF   = 5'h07;
  localparam logic [4:0] PC_CTRL  = 5'h08;
  localparam logic [4:0] PD_LATCH = 5'h09;
  localparam logic [4:0] PD_DIR   = 5'h0a;
  localparam logic [4:0] PD_CTRL  = 5'h0b;
  localparam logic [4:0] PE_LATCH = 5'h0c;
  localparam logic [4:0] PE_DIR   = 5'h0d;
  localparam logic [4:0] PE_CTRL  = 5'h0e;
  localparam logic [4:0] PF_LATCH = 5'h0f;
  localparam logic [4:0] PF_OFF   = 5'h10;
  localparam logic [4:0] PF_CTRL  = 5'h11;
  localparam logic [4:0] PG_LATCH = 5'h12;
  localparam logic [4:0] PG_DIR   = 5'h13;
  localparam logic [4:0] PG_CTRL  = 5'h14;
  localparam logic [4:0] PIN_ABD  = 5'h15;
  localparam logic [4:0] PIN_EG   = 5'h16;

  // Implemented bits per register; the rest read zero
  localparam logic [7:0] REG_MASK [REG_N] = '{
    8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h3f, 8'h1f, 8'hff, 8'hff, 8'hff,
    8'h0f, 8'h0f, 8'h0f, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff,
    8'h3f, 8'h3f, 8'h3f};
  // Directions and drive-off bits reset to one: nothing drives
  localparam logic [7:0] REG_RST [REG_N] = '{
    8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
    8'h00, 8'h0f, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00,
    8'h00, 8'h3f, 8'h00};

  // Field positions inside PA_EDGE
  localparam int EDGE_RISE_LSB = 0;
  localparam int EDGE_FALL_LSB = 3;
  // Port bit assignments of single-pin functions
  localparam int PA_CAN_BIT  = 3;
  localparam int PD_TMR_BIT  = 0;
  localparam int PD_SCK_BIT  = 1;
  localparam int PD_SI_BIT   = 3;
  localparam int PG_RX_BIT   = 2;
  localparam int PG_CAPA_BIT = 4;
  localparam int PG_CAPB_BIT = 5;

endpackage

`default_nettype wire

//--- tb/pinmux_sva.sv
// Checker for the port pin multiplexer, bound to its top module.
// Assumes APB, pins and pulses are all timed by pclk.
`default_nettype none
module pinmux_sva (
  input wire logic                            pclk,             // Clock
  input wire logic                            presetn,          // Reset, low
  input wire logic                            psel,             // Select
  input wire logic                            penable,          // Access phase
  input wire logic                            pwrite,           // Write
  input wire logic [pinmux_pkg::ADDR_W-1:0]   paddr,            // Address
  input wire logic                            pready,           // Ready
  input wire logic                            pslverr,          // Error
  input wire logic [3:0]                      pa_in,            // Port a pins
  input wire logic [3:0]                      pa_oe,            // Port a drive
  input wire logic [3:0]                      pa_pullup,        // Port a pull-ups
  input wire logic [7:0]                      pc_oe,            // Port c drive
  input wire logic [7:0]                      pf_oe,            // Port f drive
  input wire logic [5:0]                      pg_in,            // Port g pins
  input wire logic [5:0]                      pg_oe,            // Port g drive
  input wire logic [2:0]                      ext_irq,          // Edge pulses
  input wire logic                            can_ext_clock_in, // CAN clock
  input wire logic                            cap_trigger_a,    // Capture a
  input wire logic                            cap_trigger_b     // Capture b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Sticky once a write lands; pads settle one edge later, so no race
  logic wrote;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wrote <= 1'b0;
    else if (psel && penable && pready && pwrite) wrote <= 1'b1;
  end
  AST_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not in second access cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error outside ready");
  AST_RANGE_ERR: assert property (pready && paddr[11:7] != 5'h00 |-> pslverr)
    else $error("out of range access not refused");
  AST_IDLE_AFTER_RESET: assert property (!wrote |-> (pa_oe | pg_oe) == 8'h00
    && (pc_oe | pf_oe) == 8'h00)
    else $error("pin driven before configuration");
  AST_PULL_INPUT_ONLY: assert property ((pa_pullup & pa_oe) == 4'h0)
    else $error("pull-up on driven pin");
  AST_IRQ_CAUSE: assert property (ext_irq != 3'h0 |-> ((($past(pa_in[2:0]) ^ $past(pa_in[2:0], 2))
    | ($past(pa_in[2:0], 2) ^ $past(pa_in[2:0], 3))) & ext_irq) == ext_irq)
    else $error("interrupt pulse without pin edge");
  AST_CAN_CLK: assert property (can_ext_clock_in |-> $past(pa_in[pinmux_pkg::PA_CAN_BIT]))
    else $error("CAN clock high without pin");
  AST_CAP_A: assert property (cap_trigger_a |-> $past(pg_in[pinmux_pkg::PG_CAPA_BIT]))
    else $error("capture a without pin");
  AST_CAP_B: assert property (cap_trigger_b |-> $past(pg_in[pinmux_pkg::PG_CAPB_BIT]))
    else $error("capture b without pin");
  COV_WRITE: cover property (psel && penable && pready && pwrite);
  COV_ERR: cover property (pslverr);
  COV_IRQ: cover property (ext_irq != 3'h0);
  COV_CAP: cover property (cap_trigger_a && cap_trigger_b);
endmodule
`default_nettype wire

//--- tb/pin_board.sv
// Board model: resolves two-way pad levels from design drive and board drive.
// Assumes the board drives every pin the design leaves undriven.
`default_nettype none
module pin_board (
  input  wire logic [3:0] pa_out, // Port a data
  input  wire logic [3:0] pa_oe,  // Port a drive
  input  wire logic [3:0] pa_brd, // Board level a
  output logic      [3:0] pa_in,  // Pin a level
  input  wire logic [3:0] pd_out, // Port d data
  input  wire logic [3:0] pd_oe,  // Port d drive
  input  wire logic [3:0] pd_brd, // Board level d
  output logic      [3:0] pd_in,  // Pin d level
  input  wire logic [7:0] pe_out, // Port e data
  input  wire logic [7:0] pe_oe,  // Port e drive
  input  wire logic [7:0] pe_brd, // Board level e
  output logic      [7:0] pe_in,  // Pin e level
  input  wire logic [5:0] pg_out, // Port g data
  input  wire logic [5:0] pg_oe,  // Port g drive
  input  wire logic [5:0] pg_brd, // Board level g
  output logic      [5:0] pg_in   // Pin g level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Board drivers are weak: the chip wins wherever it drives
  assign pa_in = pa_oe & pa_out | ~pa_oe & pa_brd;
  assign pd_in = pd_oe & pd_out | ~pd_oe & pd_brd;
  assign pe_in = pe_oe & pe_out | ~pe_oe & pe_brd;
  assign pg_in = pg_oe & pg_out | ~pg_oe & pg_brd;
endmodule
`default_nettype wire

//--- tb/tb.sv
// Bench for the port pin multiplexer: APB master, register model, pad checks.
// Assumes the board model feeds resolved pad levels back into the pins.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, can_ext_clock_in, tmr8_a_count_in, csi_a_clock_in, csi_a_data_in;
  logic async_rx_in, cap_trigger_a, cap_trigger_b;
  logic [3:0] pa_out, pa_oe, pa_pullup, pa_in, pd_out, pd_oe, pd_in, pa_brd = 4'h0, pd_brd = 4'h0;
  logic [4:0] pb_in = 5'h00, adc_in_sel;
  logic [7:0] pc_out, pc_oe, pe_out, pe_oe, pe_in, pf_out, pf_oe, pe_brd = 8'h00;
  logic [7:0] meter12_pwm = 8'h00, meter34_pwm = 8'h00, lcd_segment_zero = 8'h00, m [21];
  logic [5:0] pg_out, pg_oe, pg_in, pg_brd = 6'h00;
  logic [2:0] ext_irq;
  pinmux_pkg::alt_t pd_alt = '0, pg_alt = '0;
  int error_cnt = 0, n_checks = 0;
  port_pin_function_mux uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pa_in, .pa_out, .pa_oe, .pa_pullup, .pb_in, .adc_in_sel, .pc_out, .pc_oe,
    .pd_in, .pd_out, .pd_oe, .pe_in, .pe_out, .pe_oe, .pf_out, .pf_oe, .pg_in, .pg_out, .pg_oe,
    .meter12_pwm, .meter34_pwm, .pd_alt, .lcd_segment_zero, .pg_alt, .ext_irq, .can_ext_clock_in,
    .tmr8_a_count_in, .csi_a_clock_in, .csi_a_data_in, .async_rx_in, .cap_trigger_a,
    .cap_trigger_b);
  pin_board brd (.pa_out, .pa_oe, .pa_brd, .pa_in, .pd_out, .pd_oe, .pd_brd, .pd_in, .pe_out,
    .pe_oe, .pe_brd, .pe_in, .pg_out, .pg_oe, .pg_brd, .pg_in);
  // 20 MHz system clock
  always #25 pclk = ~pclk;
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an idle edge follows so no strobe is set twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("[ERR] %0t no ready", $time);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Only the low byte is kept; upper data bits are random noise
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    apb(1'b1, {5'h00, i, 2'b00}, {24'($urandom), d});
    if (i < 5'h15) m[i] = d & pinmux_pkg::REG_MASK[i];
    chk(32'(err), 32'h0);
  endtask
  task automatic rchk(input logic [4:0] i, input logic [31:0] exp);
    apb(1'b0, {5'h00, i, 2'b00}, 32'h0);
    chk({err, rd[30:0]}, exp);
  endtask
  // Pad drive and routed pin functions against the register model
  task automatic pads;
    logic [31:0] x;
    logic [7:0]  ce;
    ce = {8{m[14][0]}};
    x = {~m[1][3:0] & ~m[2][3:0], m[0][3:0] & ~m[2][3:0], m[3][3:0] & (m[1][3:0] | m[2][3:0])};
    chk({pa_oe, pa_out, pa_pullup}, x);
    chk({pc_out, pc_oe}, {m[8] & meter12_pwm | ~m[8] & m[6], m[8] | ~m[7]});
    x = {m[11][3:0] & pd_alt.o[3:0] | ~m[11][3:0] & m[9][3:0],
      m[11][3:0] & pd_alt.oe[3:0] | ~m[11][3:0] & ~m[10][3:0]};
    chk({pd_out, pd_oe}, x);
    chk({pe_out, pe_oe}, {ce & lcd_segment_zero | ~ce & m[12], ce | ~m[13]});
    chk({pf_out, pf_oe}, {m[17] & meter34_pwm | ~m[17] & m[15], m[17] | ~m[16]});
    x = {m[20][5:0] & pg_alt.o[5:0] | ~m[20][5:0] & m[18][5:0],
      m[20][5:0] & pg_alt.oe[5:0] | ~m[20][5:0] & ~m[19][5:0]};
    chk({pg_out, pg_oe}, x);
    x = {pa_in[3] & m[2][3], pd_in[0] & m[11][0], pd_in[1] & m[11][1], pd_in[3] & m[11][3],
      pg_in[2] & m[20][2], pg_in[4] & m[20][4], pg_in[5] & m[20][5]};
    chk({can_ext_clock_in, tmr8_a_count_in, csi_a_clock_in, csi_a_data_in, async_rx_in,
      cap_trigger_a, cap_trigger_b}, x);
    chk(adc_in_sel, m[5][4:0]);
  endtask
  initial begin
    int cnt;
    logic [11:0] bad [3];
    bad = '{12'h05c, 12'h080, 12'h002};
    void'($urandom(32'hecc7));
    for (int i = 0; i < 21; i++) m[i] = pinmux_pkg::REG_RST[i];
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and idle pads
    for (int i = 0; i < 21; i++) rchk(5'(i), 32'(m[i]));
    pads();
    // Unmapped, out of range and misaligned places are refused
    for (int i = 0; i < 3; i++) begin
      apb(1'(i), bad[i], 32'hff);
      chk({err, rd[30:0]}, 32'h8000_0000);
    end
    rchk(5'h00, 32'(m[0]));
    // Random configuration, peripheral and board values
    for (int it = 0; it < 30; it++) begin
      for (int i = 0; i < 23; i++) wr(5'(i), 8'($urandom));
      {pa_brd, pd_brd, pe_brd, pg_brd, pb_in} <= 27'($urandom);
      {meter12_pwm, meter34_pwm, lcd_segment_zero} <= 24'($urandom);
      {pd_alt, pg_alt} <= 32'($urandom);
      repeat (3) @(posedge pclk);
      pads();
      for (int i = 0; i < 21; i++) rchk(5'(i), 32'(m[i]));
      rchk(5'h15, {19'h0, pd_in, pb_in & ~m[5][4:0], pa_in});
      rchk(5'h16, {18'h0, pg_in, pe_in});
    end
    // Edge select per pin: none, rise, fall, both
    pa_brd <= 4'h0;
    wr(pinmux_pkg::PA_CTRL, 8'h07);
    for (int e = 0; e < 4; e++) begin
      wr(pinmux_pkg::PA_EDGE, {2'b00, {3{e[1]}}, {3{e[0]}}});
      cnt = 0;
      pa_brd <= 4'h7;
      repeat (5) @(posedge pclk) cnt += $countones(ext_irq);
      pa_brd <= 4'h0;
      repeat (5) @(posedge pclk) cnt += $countones(ext_irq);
      chk(32'(cnt), 32'(3 * (e[0] + e[1])));
    end
    end_sim();
  end
endmodule
bind port_pin_function_mux pinmux_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .pa_in, .pa_oe, .pa_pullup, .pc_oe, .pf_oe, .pg_in, .pg_oe, .ext_irq,
  .can_ext_clock_in, .cap_trigger_a, .cap_trigger_b);
`default_nettype wire
